// *** core/power_mode_regs.svh ***
// register offsets, field positions and reset values of the power mode block
`ifndef POWER_MODE_REGS_SVH
`define POWER_MODE_REGS_SVH

`define PMC_INDEX        8'h87
`define PMC_ADDR         12'h21C
`define PMC_RESET        8'h00
`define PMC_RW_MASK      8'h3B
`define PMC_BIT_STANDBY  0
`define PMC_BIT_SLEEP    1
`define PMC_BIT_FLAG1    3
`define PMC_BIT_FLAG2    4
`define PMC_BIT_FLAG3    5
`define STAT_ADDR        12'h220
`define WAKE_ADDR        12'h224
`define WAKE_RESET       5'h1F
`define NOP_COUNT        2'd3

`endif

// *** core/power_mode_pkg.sv ***
// types of the power mode block
`default_nettype none
package power_mode_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'b00,
        MODE_STANDBY = 2'b01,
        MODE_SLEEP   = 2'b10
    } pmode_type;

    typedef struct packed {
        logic cpu_clk_en;
        logic wdt_run;
        logic flash_deep_sleep;
        logic fast_clk_en;
    } gate_type;

    typedef struct packed {
        logic ext_irq;
        logic rtc_irq;
        logic other_irq;
        logic debug_req;
        logic wake_pin;
    } wake_type;
endpackage
`default_nettype wire

// *** core/axil_slave_port.sv ***
// small axi4-lite slave front end: one write and one read at a time
`default_nettype none
module axil_slave_port (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // axi4-lite
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // register side
    output logic             wr_en,
    output logic [11:0]      wr_addr,
    output logic [7:0]       wr_data,
    input  wire logic        wr_ok,
    output logic [11:0]      rd_addr,
    input  wire logic [7:0]  rd_data,
    input  wire logic        rd_ok
);
    logic        aw_r;
    logic        w_r;
    logic [11:0] awaddr_r;
    logic [7:0]  wdata_r;
    logic        wlane_r;
    logic        ar_r;
    logic [11:0] araddr_r;

    assign s_axi_awready = !aw_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_r && !s_axi_bvalid;
    assign s_axi_arready = !ar_r && !s_axi_rvalid;
    assign wr_en   = aw_r && w_r && !s_axi_bvalid && wlane_r;
    assign wr_addr = awaddr_r;
    assign wr_data = wdata_r;
    assign rd_addr = araddr_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_r         <= 1'b0;
            w_r          <= 1'b0;
            awaddr_r     <= 12'h000;
            wdata_r      <= 8'h00;
            wlane_r      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_r     <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_r     <= 1'b1;
                wdata_r <= s_axi_wdata[7:0];
                wlane_r <= s_axi_wstrb[0];
            end
            if (aw_r && w_r && !s_axi_bvalid) begin
                aw_r         <= 1'b0;
                w_r          <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ar_r         <= 1'b0;
            araddr_r     <= 12'h000;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                ar_r     <= 1'b1;
                araddr_r <= s_axi_araddr;
            end else if (ar_r) begin
                ar_r         <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rd_data};
                s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // axil_slave_port
`default_nettype wire

// *** core/power_mode_control.sv ***
// power mode controller: normal, standby and sleep with wakeup
// What this block does
// - the two request bits decode as 00 normal, 01 standby, sleep bit set sleep.
// - writing one to bit 1 enters sleep, and hardware clears it on wakeup.
// - writing one to bit 0 enters standby, and hardware clears it on wakeup.
// - standby stops the processor clock and the watchdog, others as enabled.
// - standby ends on any enabled interrupt, a reset or a debug request.
// - sleep ends only on external or rtc interrupt, wake pin change, debug or a reset.
// - sleep puts flash in deep sleep, drops the fast clock, stops the watchdog.
// - normal mode runs every module at full speed unless disabled.
// - bits 5, 4 and 3 are read-write spare flags resetting to zero.
//
// Added by the designer: register access over AXI4-Lite.
`include "power_mode_regs.svh"
`default_nettype none
module power_mode_control
    import power_mode_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // axi4-lite
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // wakeup sources
    input  wire wake_type    wake_in,
    // gating and mode outputs
    output gate_type         gate_out,
    output pmode_type        mode_out
);
    // ************************************************************
    // bus front end
    // ************************************************************
    logic        wr_en;
    logic [11:0] wr_addr;
    logic [7:0]  wr_data;
    logic [11:0] rd_addr;
    logic [7:0]  rd_data;
    logic        wr_ok;
    logic        rd_ok;

    axil_slave_port axil_slave_port_inst (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_ok         (wr_ok),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    // ************************************************************
    // address decode
    // ************************************************************
    wire wr_pmc  = wr_en && (wr_addr == `PMC_ADDR);
    wire wr_wake = wr_en && (wr_addr == `WAKE_ADDR);
    assign wr_ok = (wr_addr == `PMC_ADDR) || (wr_addr == `WAKE_ADDR)
                || (wr_addr == `STAT_ADDR);
    assign rd_ok = (rd_addr == `PMC_ADDR) || (rd_addr == `WAKE_ADDR)
                || (rd_addr == `STAT_ADDR);

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] pmc_r;
    logic [7:0] pmc_nxt;
    logic [4:0] wake_en_r;
    logic       pin_prev_r;
    pmode_type  mode_r;
    pmode_type  mode_nxt;

    // wake enables: bit0 ext, 1 rtc, 2 other irq, 3 debug, 4 wake pin
    wire [4:0] wake_vec = {wake_in.wake_pin ^ pin_prev_r, wake_in.debug_req,
                           wake_in.other_irq, wake_in.rtc_irq,
                           wake_in.ext_irq};
    wire [4:0] wake_hit = wake_vec & wake_en_r;

    // any enabled interrupt or debug request; the wake pin is not used
    wire wake_standby = |wake_hit[3:0];
    // only external, rtc, wake pin change or debug
    wire wake_sleep = wake_hit[0] || wake_hit[1]
                   || wake_hit[3] || wake_hit[4];

    wire [1:0] req = pmc_r[`PMC_BIT_SLEEP:`PMC_BIT_STANDBY];

    // ************************************************************
    // mode state machine
    // ************************************************************
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            MODE_NORMAL: begin
                if (req[1]) begin
                    mode_nxt = MODE_SLEEP;
                end else if (req[0]) begin
                    mode_nxt = MODE_STANDBY;
                end
            end
            MODE_STANDBY: begin
                if (wake_standby) begin
                    mode_nxt = MODE_NORMAL;
                end
            end
            MODE_SLEEP: begin
                if (wake_sleep) begin
                    mode_nxt = MODE_NORMAL;
                end
            end
            default: begin
                mode_nxt = MODE_NORMAL;
            end
        endcase
    end

    // hardware clear on wakeup; a write in the same cycle is kept
    wire wake_now = (mode_r != MODE_NORMAL) && (mode_nxt == MODE_NORMAL);

    always_comb begin
        pmc_nxt = pmc_r;
        if (wake_now) begin
            pmc_nxt[`PMC_BIT_SLEEP]   = 1'b0;
            pmc_nxt[`PMC_BIT_STANDBY] = 1'b0;
        end
        if (wr_pmc) begin
            pmc_nxt = (pmc_nxt & ~`PMC_RW_MASK)
                    | (wr_data & `PMC_RW_MASK);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pmc_r      <= `PMC_RESET;
            mode_r     <= MODE_NORMAL;
            wake_en_r  <= `WAKE_RESET;
            pin_prev_r <= 1'b0;
        end else begin
            pmc_r      <= pmc_nxt;
            mode_r     <= mode_nxt;
            pin_prev_r <= wake_in.wake_pin;
            if (wr_wake) begin
                wake_en_r <= wr_data[4:0];
            end
        end
    end

    // ************************************************************
    // clock gating and read data
    // ************************************************************
    wire next_is_normal = (mode_nxt == MODE_NORMAL);
    wire next_is_sleep  = (mode_nxt == MODE_SLEEP);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gate_out <= '{1'b1, 1'b1, 1'b0, 1'b1};
        end else begin
            gate_out.cpu_clk_en       <= next_is_normal;
            gate_out.wdt_run          <= next_is_normal;
            gate_out.flash_deep_sleep <= next_is_sleep;
            gate_out.fast_clk_en      <= !next_is_sleep;
        end
    end

    assign mode_out = mode_r;

    assign rd_data = (rd_addr == `PMC_ADDR)  ? pmc_r :
                     (rd_addr == `WAKE_ADDR) ? {3'b000, wake_en_r} :
                     (rd_addr == `STAT_ADDR) ? {6'h00, mode_r} : 8'h00;
endmodule // power_mode_control
`default_nettype wire

// *** tb/power_mode_control_assertions.sv ***
// concurrent checks on the ports of the power mode controller
`default_nettype none
module power_mode_checker
    import power_mode_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // write channels
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    // mode side
    input wire wake_type    wake_in,
    input wire gate_type    gate_out,
    input wire pmode_type   mode_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic quiet_s;
    logic quiet_b;
    assign quiet_s = !wake_in.ext_irq && !wake_in.rtc_irq
                  && !wake_in.debug_req;
    assign quiet_b = quiet_s && !wake_in.other_irq;

    // request write accepted with both channels on one edge
    sequence s_req_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == 12'h21C && s_axi_wstrb[0];
    endsequence

    a_sleep_entry: assert property (
        s_req_wr ##0 (s_axi_wdata[1] && mode_out == MODE_NORMAL && quiet_s)
        |-> ##[1:4] mode_out == MODE_SLEEP) else $error("no sleep entry");
    a_standby_entry: assert property (
        s_req_wr ##0 (s_axi_wdata[1:0] == 2'b01 && mode_out == MODE_NORMAL
        && quiet_b) |-> ##[1:4] mode_out == MODE_STANDBY)
        else $error("no standby entry");
    a_mode_legal: assert property (mode_out != 2'b11)
        else $error("illegal mode code");
    a_sleep_gates: assert property (mode_out == MODE_SLEEP |->
        !gate_out.wdt_run && gate_out.flash_deep_sleep
        && !gate_out.fast_clk_en) else $error("sleep gating wrong");
    a_standby_gates: assert property (mode_out == MODE_STANDBY |->
        !gate_out.cpu_clk_en && !gate_out.wdt_run)
        else $error("standby gating wrong");
    a_normal_gates: assert property (mode_out == MODE_NORMAL |->
        gate_out == 4'b1101) else $error("normal gating wrong");
    a_sleep_holds: assert property (
        mode_out == MODE_SLEEP && quiet_s && $stable(wake_in.wake_pin)
        |=> mode_out == MODE_SLEEP) else $error("sleep left without source");
    a_standby_holds: assert property (
        mode_out == MODE_STANDBY && quiet_b |=> mode_out == MODE_STANDBY)
        else $error("standby left without source");
    a_ext_wakes: assert property (
        mode_out != MODE_NORMAL && wake_in.ext_irq |=> mode_out == MODE_NORMAL)
        else $error("external wake ignored");
endmodule // power_mode_checker

bind power_mode_control power_mode_checker power_mode_checker_inst (
    .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .wake_in, .gate_out, .mode_out);
`default_nettype wire

// *** tb/power_mode_control_tb.sv ***
// self-checking bench of the power mode controller
`default_nettype none
module power_mode_control_tb
    import power_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    wake_type    wake_in;
    gate_type    gate_out;
    pmode_type   mode_out;
    int          failures, comparisons;

    power_mode_control power_mode_control_inst (.clk_sys, .rst_n,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .wake_in, .gate_out, .mode_out);

    initial begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // each channel is released at the edge where its ready is seen high
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bit aw_t;
        bit w_t;
        aw_t = 1'b0;
        w_t  = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_t && w_t)) begin
            @(posedge clk_sys);
            if (!aw_t && s_axi_awready) begin
                aw_t = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_t && s_axi_wready) begin
                w_t = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rdr(input logic [11:0] a);
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        rd  = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // one-cycle pulse on a wake source, seen at the next edge
    task automatic pulse(input int b);
        @(posedge clk_sys);
        wake_in[b] <= 1'b1;
        @(posedge clk_sys);
        wake_in[b] <= 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic enter(input logic [7:0] v, input pmode_type m);
        wr(12'h21C, v);
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 6 && mode_out !== m; i++) @(negedge clk_sys);
        chk("mode entry", m, mode_out);
    endtask

    task automatic t_reset;
        rdr(12'h21C);
        chk("pmc reset", 32'h0, rd);
        rdr(12'h224);
        chk("wake enable reset", 32'h1F, rd);
        chk("gates reset", 4'hD, gate_out);
    endtask

    task automatic t_flags;
        wr(12'h21C, 8'hFC);
        chk("good write resp", 2'b00, rsp);
        rdr(12'h21C);
        chk("flags", 32'h38, rd);
        chk("good read resp", 2'b00, rsp);
        s_axi_wstrb <= 4'hE;
        wr(12'h21C, 8'h00);
        s_axi_wstrb <= 4'hF;
        rdr(12'h21C);
        chk("masked lane", 32'h38, rd);
        wr(12'h300, 8'hFF);
        chk("bad write resp", 2'b10, rsp);
        rdr(12'h300);
        chk("bad read resp", 2'b10, rsp);
        chk("bad read data", 32'h0, rd);
    endtask

    task automatic t_standby;
        int src [4] = '{4, 3, 2, 1};
        foreach (src[i]) begin
            enter(8'h39, MODE_STANDBY);
            chk("standby gates", 2'b00, gate_out[3:2]);
            rdr(12'h220);
            chk("status", 32'h1, rd);
            pulse(0);
            chk("pin no wake", MODE_STANDBY, mode_out);
            pulse(src[i]);
            chk("standby wake", MODE_NORMAL, mode_out);
            chk("gates back", 4'hD, gate_out);
            rdr(12'h21C);
            chk("idle cleared", 32'h38, rd);
        end
    endtask

    task automatic t_sleep;
        int src [4] = '{4, 3, 1, 0};
        logic [7:0] v [4] = '{8'h3A, 8'h3B, 8'h3A, 8'h3A};
        foreach (src[i]) begin
            enter(v[i], MODE_SLEEP);
            chk("sleep gates", 3'b010, gate_out[2:0]);
            pulse(2);
            chk("irq no wake", MODE_SLEEP, mode_out);
            pulse(src[i]);
            chk("sleep wake", MODE_NORMAL, mode_out);
            rdr(12'h21C);
            chk("stop cleared", 32'h38, rd);
        end
    endtask

    task automatic t_mask;
        wr(12'h224, 8'h1D);
        enter(8'h3A, MODE_SLEEP);
        pulse(3);
        chk("masked rtc", MODE_SLEEP, mode_out);
        pulse(4);
        chk("ext wake", MODE_NORMAL, mode_out);
        wr(12'h224, 8'h1F);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        wake_in = '0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1;
        t_reset;
        t_flags;
        t_standby;
        t_sleep;
        t_mask;
        report_and_stop;
    end

    initial begin
        #100000;
        failures++;
        report_and_stop;
    end
endmodule // power_mode_control_tb
`default_nettype wire
